// *** hdl/pfm_pin_mux.sv ***
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
module pfm_pin_mux
(
  input wire logic mclk,                                      // system clock, 100 MHz
  input wire logic rst,                                       // synchronous reset, high
  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  input wire logic [31:0] s_axi_awaddr,                       // write address
  input wire logic [2:0] s_axi_awprot,                        // write protection, unused
  input wire logic s_axi_awvalid,                             // write address valid
  output logic s_axi_awready,                                 // write address ready
  input wire logic [31:0] s_axi_wdata,                        // write data
  input wire logic [3:0] s_axi_wstrb,                         // write byte strobes
  input wire logic s_axi_wvalid,                              // write data valid
  output logic s_axi_wready,                                  // write data ready
  output logic [1:0] s_axi_bresp,                             // write response
  output logic s_axi_bvalid,                                  // write response valid
  input wire logic s_axi_bready,                              // write response ready
  input wire logic [31:0] s_axi_araddr,                       // read address
  input wire logic [2:0] s_axi_arprot,                        // read protection, unused
  input wire logic s_axi_arvalid,                             // read address valid
  output logic s_axi_arready,                                 // read address ready
  output logic [31:0] s_axi_rdata,                            // read data
  output logic [1:0] s_axi_rresp,                             // read response
  output logic s_axi_rvalid,                                  // read data valid
  input wire logic s_axi_rready,                              // read data ready
  // ----------------------------------------------------------------
  // gpio block side
  // ----------------------------------------------------------------
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] port_direction_reg, // 1 = out
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] gpio_out,   // gpio levels
  output logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] gpio_in,        // pin levels
  // ----------------------------------------------------------------
  // package pins
  // ----------------------------------------------------------------
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_in,     // pad level
  output logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_out,        // pad drive
  output logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_oe,         // pad enable
  // ----------------------------------------------------------------
  // on-chip peripheral side, indexed by pfm_func_type
  // ----------------------------------------------------------------
  input wire logic [pfm_pkg::PFM_NFUNC-1:0] periph_out,      // function output levels
  input wire logic [pfm_pkg::PFM_NFUNC-1:0] periph_oe,       // function output enables
  output logic [pfm_pkg::PFM_NFUNC-1:0] periph_in,           // function input levels
  output logic [pfm_pkg::PFM_NFUNC-1:0] func_routed          // function has a pin
);
  import pfm_pkg::*;

  localparam int LW = PFM_LAST_PIN - PFM_FIRST_PIN + 1;      // pins handled

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] sel_low_q, sel_low_d;      // pin_function_select_low
  logic [31:0] sel_high_q, sel_high_d;    // pin_function_select_high
  logic aw_have_q, aw_have_d;             // write address held
  logic [31:0] aw_addr_q, aw_addr_d;      // held write address
  logic w_have_q, w_have_d;               // write data held
  logic [31:0] w_data_q, w_data_d;        // held write data
  logic [3:0] w_strb_q, w_strb_d;         // held write strobes
  logic awready_q, awready_d;             // address channel open
  logic wready_q, wready_d;               // data channel open
  logic bvalid_q, bvalid_d;               // write answer pending
  logic [1:0] bresp_q, bresp_d;           // write answer code
  logic arready_q, arready_d;             // read channel open
  logic rvalid_q, rvalid_d;               // read answer pending
  logic [31:0] rdata_q, rdata_d;          // read answer data
  logic [1:0] rresp_q, rresp_d;           // read answer code

  // ----------------------------------------------------------------
  // pin and routing state
  // ----------------------------------------------------------------
  logic [LW-1:0] sync1_q, sync2_q;        // two-stage pad synchroniser
  logic [LW-1:0] pin_out_q, pin_oe_q;     // registered pad drive
  logic [LW-1:0] gpio_in_q;               // registered pad levels
  logic [PFM_NFUNC-1:0] periph_in_q;      // registered function inputs
  logic [PFM_NFUNC-1:0] routed_q;         // registered routed flags

  pfm_route_if rif ();                    // carrier to the routing cell

  // merge a byte-strobed write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // write channel: address and data in either order, answer after both
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_low_d = sel_low_q;
    sel_high_d = sel_high_q;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    // answer leaves once the master takes it
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // catch address and data independently
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    // both halves present: commit on this very edge
    if (aw_have_d && w_have_d)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = PFM_RESP_OKAY;
      if (aw_addr_d == PFM_SEL_LOW_ADDR)
        sel_low_d = merge(sel_low_q, w_data_d, w_strb_d);
      else if (aw_addr_d == PFM_SEL_HIGH_ADDR)
        sel_high_d = merge(sel_high_q, w_data_d, w_strb_d);
      else
        bresp_d = PFM_RESP_SLVERR;  // unmapped: nothing stored
    end
    // channels close while a half is held or the answer waits
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  // ----------------------------------------------------------------
  // read channel: one read in flight, answer one cycle after the take
  // ----------------------------------------------------------------
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = PFM_RESP_OKAY;
      if (s_axi_araddr == PFM_SEL_LOW_ADDR)
        rdata_d = sel_low_q;
      else if (s_axi_araddr == PFM_SEL_HIGH_ADDR)
        rdata_d = sel_high_q;
      else
      begin
        rdata_d = 32'h0000_0000;   // unmapped reads zero with an error
        rresp_d = PFM_RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  // ----------------------------------------------------------------
  // bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_low_q <= PFM_SEL_RESET;
      sel_high_q <= PFM_SEL_RESET;
      aw_have_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= PFM_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= PFM_RESP_OKAY;
    end
    else
    begin
      sel_low_q <= sel_low_d;
      sel_high_q <= sel_high_d;
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // routing cell hookup
  // ----------------------------------------------------------------
  assign rif.sel_low = sel_low_q;
  assign rif.sel_high = sel_high_q;
  assign rif.port_dir = port_direction_reg;
  assign rif.gpio_out = gpio_out;
  assign rif.pin_val = sync2_q;   // only the second stage is ever looked at
  assign rif.periph_out = periph_out;
  assign rif.periph_oe = periph_oe;

  // pin tables live in the package
  pfm_route u_route
  (
    .rt (rif.route)
  );

  // ----------------------------------------------------------------
  // pad synchroniser and registered routing outputs; the extra stage
  // costs a cycle but keeps every pad and peripheral signal glitch free
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      pin_out_q <= '0;
      pin_oe_q <= '0;
      gpio_in_q <= '0;
      periph_in_q <= '0;
      routed_q <= '0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      pin_out_q <= rif.pin_out_d;
      pin_oe_q <= rif.pin_oe_d;
      gpio_in_q <= sync2_q;
      periph_in_q <= rif.periph_in_d;
      routed_q <= rif.routed_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign gpio_in = gpio_in_q;
  assign periph_in = periph_in_q;
  assign func_routed = routed_q;

endmodule

// *** hdl/pfm_pkg.sv ***
// ----------------------------------------------------------------
// pin function mux: shared constants and tables
// ----------------------------------------------------------------
package pfm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [31:0] PFM_SEL_LOW_ADDR = 32'hE002_C000;  // pin_function_select_low
  localparam logic [31:0] PFM_SEL_HIGH_ADDR = 32'hE002_C004; // pin_function_select_high
  localparam logic [31:0] PFM_SEL_RESET = 32'h0000_0000;     // every field reads gpio after reset

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PFM_FIELD_W = 2;          // bits per pin field
  localparam int PFM_PINS_PER_REG = 16;    // fields per select word
  localparam int PFM_FIRST_PIN = 3;        // lowest pin handled here
  localparam int PFM_LAST_PIN = 20;        // highest pin handled here
  localparam int PFM_NFUNC = 38;           // function ids, 0 meaning none
  localparam logic [1:0] PFM_CODE_GPIO = 2'h0; // field code for general-purpose i/o

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] PFM_RESP_OKAY = 2'h0;   // mapped access
  localparam logic [1:0] PFM_RESP_SLVERR = 2'h2; // unmapped access

  // peripheral signals a pin can be joined to
  typedef enum logic [5:0] {
    FN_NONE, FN_I2C_SDA, FN_T0_MAT0, FN_EXT_IRQ_1, FN_SPI0_SCK, FN_T0_CAP1,
    FN_SPI0_MISO, FN_T0_MAT1, FN_SPI0_MOSI, FN_T0_CAP2, FN_SPI0_SSEL, FN_PWM2,
    FN_EXT_IRQ_2, FN_U1_TXD, FN_PWM4, FN_U1_RXD, FN_PWM6, FN_EXT_IRQ_3,
    FN_U1_RTS, FN_T1_CAP0, FN_U1_CTS, FN_T1_CAP1, FN_U1_DSR, FN_T1_MAT0,
    FN_U1_DTR, FN_T1_MAT1, FN_U1_DCD, FN_U1_RI, FN_EXT_IRQ_0, FN_T0_MAT2,
    FN_T1_CAP2, FN_SPI1_SCK, FN_T1_MAT2, FN_T1_CAP3, FN_SPI1_MISO, FN_T1_MAT3,
    FN_SPI1_MOSI, FN_SPI1_SSEL
  } pfm_func_type;

  // two-bit select field of a pin, taken from the proper word
  function automatic logic [1:0] pfm_field(input logic [31:0] lo, input logic [31:0] hi,
                                           input int pin);
    logic [31:0] w;
    w = (pin < PFM_PINS_PER_REG) ? lo : hi;
    return w[PFM_FIELD_W*(pin % PFM_PINS_PER_REG) +: PFM_FIELD_W];
  endfunction

  // function joined to a pin for a non-gpio code; reserved codes give none
  function automatic pfm_func_type pfm_func(input int pin, input logic [1:0] code);
    pfm_func_type t [1:3];
    t = '{FN_NONE, FN_NONE, FN_NONE};
    case (pin)
      3: t = '{FN_I2C_SDA, FN_T0_MAT0, FN_EXT_IRQ_1};
      4: t = '{FN_SPI0_SCK, FN_T0_CAP1, FN_NONE};
      5: t = '{FN_SPI0_MISO, FN_T0_MAT1, FN_NONE};
      6: t = '{FN_SPI0_MOSI, FN_T0_CAP2, FN_NONE};
      7: t = '{FN_SPI0_SSEL, FN_PWM2, FN_EXT_IRQ_2};
      8: t = '{FN_U1_TXD, FN_PWM4, FN_NONE};
      9: t = '{FN_U1_RXD, FN_PWM6, FN_EXT_IRQ_3};
      10: t = '{FN_U1_RTS, FN_T1_CAP0, FN_NONE};
      11: t = '{FN_U1_CTS, FN_T1_CAP1, FN_NONE};
      12: t = '{FN_U1_DSR, FN_T1_MAT0, FN_NONE};
      13: t = '{FN_U1_DTR, FN_T1_MAT1, FN_NONE};
      14: t = '{FN_U1_DCD, FN_EXT_IRQ_1, FN_NONE};
      15: t = '{FN_U1_RI, FN_EXT_IRQ_2, FN_NONE};
      16: t = '{FN_EXT_IRQ_0, FN_T0_MAT2, FN_T0_CAP2};
      17: t = '{FN_T1_CAP2, FN_SPI1_SCK, FN_T1_MAT2};
      18: t = '{FN_T1_CAP3, FN_SPI1_MISO, FN_T1_MAT3};
      19: t = '{FN_T1_MAT2, FN_SPI1_MOSI, FN_T1_CAP2};
      20: t = '{FN_T1_MAT3, FN_SPI1_SSEL, FN_EXT_IRQ_3};
      default: t = '{FN_NONE, FN_NONE, FN_NONE};
    endcase
    return (code == PFM_CODE_GPIO) ? FN_NONE : t[code];
  endfunction

endpackage

// *** hdl/pfm_route_if.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// carrier between the register side and the routing cell
// ----------------------------------------------------------------
interface pfm_route_if;
  import pfm_pkg::*;
  logic [31:0] sel_low;                              // low select word
  logic [31:0] sel_high;                             // high select word
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] port_dir;       // gpio direction bits
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] gpio_out;       // gpio output values
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] pin_val;        // synchronised pin levels
  logic [PFM_NFUNC-1:0] periph_out;                  // peripheral output levels
  logic [PFM_NFUNC-1:0] periph_oe;                   // peripheral output enables
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] pin_out_d;      // next pin output level
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] pin_oe_d;       // next pin output enable
  logic [PFM_NFUNC-1:0] periph_in_d;                 // next peripheral input levels
  logic [PFM_NFUNC-1:0] routed_d;                    // next routed flags
  modport cfg (output sel_low, sel_high, port_dir, gpio_out, pin_val, periph_out, periph_oe,
               input pin_out_d, pin_oe_d, periph_in_d, routed_d);
  modport route (input sel_low, sel_high, port_dir, gpio_out, pin_val, periph_out, periph_oe,
                 output pin_out_d, pin_oe_d, periph_in_d, routed_d);
endinterface

// *** hdl/pfm_route.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// routing cell: pure combinational mux between pins and functions
// ----------------------------------------------------------------
module pfm_route
(
  pfm_route_if.route rt  // select words in, next routing out
);
  import pfm_pkg::*;

  // one pass over the pins; walking downward lets the lowest pin win
  // when two pins select the same input function
  always_comb
  begin
    logic [1:0] code;
    pfm_func_type fn;
    code = PFM_CODE_GPIO;
    fn = FN_NONE;
    rt.pin_out_d = '0;
    rt.pin_oe_d = '0;
    rt.periph_in_d = '0;
    rt.routed_d = '0;
    for (int p = PFM_LAST_PIN; p >= PFM_FIRST_PIN; p--)
    begin
      code = pfm_field(rt.sel_low, rt.sel_high, p);
      fn = pfm_func(p, code);
      if (code == PFM_CODE_GPIO)
      begin
        rt.pin_out_d[p] = rt.gpio_out[p];
        rt.pin_oe_d[p] = rt.port_dir[p];
      end
      else if (fn != FN_NONE)
      begin
        rt.pin_out_d[p] = rt.periph_out[fn];
        rt.pin_oe_d[p] = rt.periph_oe[fn];
        rt.periph_in_d[fn] = rt.pin_val[p];
        rt.routed_d[fn] = 1'b1;
      end
      else
      begin
        rt.pin_out_d[p] = 1'b0;
        rt.pin_oe_d[p] = 1'b0;
      end
    end
  end

endmodule

// *** test/pfm_pin_mux_assertions.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bus and routing checks seen from the mux top ports
// ----------------------------------------------------------------
module pfm_pin_mux_assertions
(
  input wire logic mclk, // clock
  input wire logic rst, // sync reset
  input wire logic [31:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // w data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic [31:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] port_direction_reg, // dir
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_oe, // pad enable
  input wire logic [pfm_pkg::PFM_NFUNC-1:0] periph_oe, // function enables
  input wire logic [pfm_pkg::PFM_NFUNC-1:0] func_routed // routed flags
);
  import pfm_pkg::*;
  // shadow of the select words; full-word writes only, as the bench issues
  logic aw_q, w_q, aw_hit, w_hit, ar_hit, both, p3_oe;
  logic [31:0] a_q, d_q, wa, wd, lo_q, hi_q;
  logic [1:0] sel3;
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] gmask; // pins whose field is gpio
  // address and data may be taken at different edges
  always_comb
  begin
    aw_hit = s_axi_awvalid && s_axi_awready;
    w_hit = s_axi_wvalid && s_axi_wready;
    ar_hit = s_axi_arvalid && s_axi_arready;
    wa = aw_hit ? s_axi_awaddr : a_q;
    wd = w_hit ? s_axi_wdata : d_q;
    both = (aw_hit || aw_q) && (w_hit || w_q);
    sel3 = lo_q[7:6];
    p3_oe = periph_oe[sel3];
    for (int p = PFM_FIRST_PIN; p <= PFM_LAST_PIN; p++)
      gmask[p] = (p < 16 ? lo_q[2*(p%16) +: 2] : hi_q[2*(p%16) +: 2]) == 2'h0;
  end
  // track half-taken writes and the stored words
  always_ff @(posedge mclk)
  begin
    aw_q <= !rst && (aw_q || aw_hit) && !both;
    w_q <= !rst && (w_q || w_hit) && !both;
    a_q <= wa;
    d_q <= wd;
    if (rst)
      lo_q <= 32'h0000_0000;
    else if (both && wa == PFM_SEL_LOW_ADDR)
      lo_q <= wd;
    if (rst)
      hi_q <= 32'h0000_0000;
    else if (both && wa == PFM_SEL_HIGH_ADDR)
      hi_q <= wd;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reset_clear_a: assert property ($fell(rst) |-> pin_oe == '0 && !s_axi_bvalid)
    else $error("pads or response not clear after reset");
  gpio_dir_a: assert property (!$past(rst) |->
    ((pin_oe ^ $past(port_direction_reg)) & $past(gmask)) == '0)
    else $error("gpio pad enable differs from direction");
  pin3_func_a: assert property (!$past(rst) && $past(sel3) != 2'h0 |->
    pin_oe[3] == $past(p3_oe)) else $error("pin 3 enable not from selected function");
  sda_routed_a: assert property (!$past(rst) |->
    func_routed[1] == ($past(sel3) == 2'h1)) else $error("data line routed flag wrong");
  low_read_a: assert property (ar_hit && s_axi_araddr == PFM_SEL_LOW_ADDR |=>
    s_axi_rvalid && s_axi_rdata == $past(lo_q)) else $error("low word read wrong");
  high_read_a: assert property (ar_hit && s_axi_araddr == PFM_SEL_HIGH_ADDR |=>
    s_axi_rvalid && s_axi_rdata == $past(hi_q)) else $error("high word read wrong");
  bad_read_a: assert property (ar_hit && s_axi_araddr != PFM_SEL_LOW_ADDR &&
    s_axi_araddr != PFM_SEL_HIGH_ADDR |=> s_axi_rresp == PFM_RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read answered wrongly");
  write_resp_a: assert property (both |=> s_axi_bvalid && s_axi_bresp ==
    ($past(wa == PFM_SEL_LOW_ADDR || wa == PFM_SEL_HIGH_ADDR) ? PFM_RESP_OKAY : PFM_RESP_SLVERR))
    else $error("write response missing or wrong");
  ready_closed_a: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
    else $error("ready open while response pending");
endmodule
bind pfm_pin_mux pfm_pin_mux_assertions chk_u (.*);

// *** test/pfm_far_model.sv ***
`timescale 1ns/1ns
// on-chip functions and board pads beyond the mux
module pfm_far_model
(
  input wire logic mclk, // clock
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_out, // pad drive
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_oe, // pad enable
  input wire logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] ext_pad, // board level
  input wire logic [pfm_pkg::PFM_NFUNC-1:0] fn_out, // wanted function levels
  input wire logic [pfm_pkg::PFM_NFUNC-1:0] fn_oe, // wanted function enables
  output logic [pfm_pkg::PFM_LAST_PIN:pfm_pkg::PFM_FIRST_PIN] pin_in, // pad level seen
  output logic [pfm_pkg::PFM_NFUNC-1:0] periph_out, // function outputs
  output logic [pfm_pkg::PFM_NFUNC-1:0] periph_oe // function enables
);
  import pfm_pkg::*;
  // function levels reach the mux one edge after the bench sets them
  always_ff @(posedge mclk)
  begin
    periph_out <= fn_out;
    periph_oe <= fn_oe;
  end
  // a released pad shows the board level, never the last drive
  always_comb
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pad);
endmodule

// *** test/pfm_pin_mux_tb.sv ***
`timescale 1ns/1ns
module pfm_pin_mux_tb;
  import pfm_pkg::*;
  logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] port_direction_reg, gpio_out, gpio_in, pin_in, pin_out;
  logic [PFM_LAST_PIN:PFM_FIRST_PIN] pin_oe, ext_pad;
  logic [PFM_NFUNC-1:0] periph_out, periph_oe, periph_in, func_routed, fn_out, fn_oe;
  int mismatches, samples_checked, cycles;
  pfm_pin_mux dut_u (.*);
  pfm_far_model far_u (.*);
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus write; valids drop as each channel is taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    done = 1'h0;
    while (!done)
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'h0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        done = 1'h1;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    done = 1'h0;
    while (!done)
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'h0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        done = 1'h1;
      end
    end
  endtask
  // routing lags the register by one edge, pad input by three
  task automatic settle;
    repeat (4) @(posedge mclk);
  endtask
  // every code of pin 3, read back each time
  task automatic t_pin3;
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(PFM_SEL_LOW_ADDR, 32'(c) << 6, PFM_RESP_OKAY);
      settle();
      chk("pin3_oe", 32'(c == 2'h0 ? port_direction_reg[3] : fn_oe[c]), 32'(pin_oe[3]));
      chk("pin3_out", 32'(c == 2'h0 ? gpio_out[3] : fn_out[c]), 32'(pin_out[3]));
      rd(PFM_SEL_LOW_ADDR, 32'(c) << 6, PFM_RESP_OKAY);
    end
    chk("irq1_in", 32'(ext_pad[3]), 32'(periph_in[FN_EXT_IRQ_1]));
  endtask
  // high word fields; direction must not steer routed pins
  task automatic t_high;
    wr(PFM_SEL_HIGH_ADDR, 32'h0000_0301, PFM_RESP_OKAY);
    settle();
    chk("pin16_oe", 32'(fn_oe[FN_EXT_IRQ_0]), 32'(pin_oe[16]));
    chk("pin20_out", 32'(fn_out[FN_EXT_IRQ_3]), 32'(pin_out[20]));
    chk("routed16", 32'h0000_0001, 32'(func_routed[FN_EXT_IRQ_0]));
    chk("routed20", 32'h0000_0001, 32'(func_routed[FN_EXT_IRQ_3]));
    fn_oe[FN_EXT_IRQ_0] <= 1'h1;
    port_direction_reg <= '0;
    settle();
    chk("pin16_oe", 32'h0000_0001, 32'(pin_oe[16]));
    chk("pin4_oe", 32'h0000_0000, 32'(pin_oe[4]));
    rd(PFM_SEL_HIGH_ADDR, 32'h0000_0301, PFM_RESP_OKAY);
    chk("gpio_in", 32'h0003_FFFF, 32'(gpio_in));
  endtask
  // top field of the low word, then an unmapped word
  task automatic t_top_bad;
    wr(PFM_SEL_LOW_ADDR, 32'h8000_0000, PFM_RESP_OKAY);
    settle();
    chk("pin15_out", 32'(fn_out[FN_EXT_IRQ_2]), 32'(pin_out[15]));
    chk("routed12", 32'h0000_0001, 32'(func_routed[FN_EXT_IRQ_2]));
    wr(32'hE002_C008, 32'hFFFF_FFFF, PFM_RESP_SLVERR);
    rd(32'hE002_C008, 32'h0000_0000, PFM_RESP_SLVERR);
    rd(PFM_SEL_LOW_ADDR, 32'h8000_0000, PFM_RESP_OKAY);
  endtask
  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    port_direction_reg = '1;
    gpio_out = '1;
    ext_pad = '1;
    fn_oe = 38'h00_0000_0002;
    fn_out = 38'h3F_FFFF_FFF5;
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    rd(PFM_SEL_LOW_ADDR, PFM_SEL_RESET, PFM_RESP_OKAY);
    rd(PFM_SEL_HIGH_ADDR, PFM_SEL_RESET, PFM_RESP_OKAY);
    chk("gpio_oe", 32'(port_direction_reg), 32'(pin_oe));
    chk("gpio_out", 32'(gpio_out), 32'(pin_out));
    t_pin3();
    t_high();
    t_top_bad();
    end_sim();
  end
endmodule
